// ### shared/chf_pkg.sv
// constants for the cell header filter and look-up index block
package chf_pkg;
    // register indices; byte address is four times the index
    localparam logic [15:0] CHF_IDX_BIT_COUNT = 16'h4002;
    localparam logic [15:0] CHF_IDX_TABLE_BASE = 16'h4004;
    localparam logic [15:0] CHF_IDX_CH_EXPECTED = 16'h4006;
    localparam logic [15:0] CHF_IDX_CH_ENABLE = 16'h4008;
    localparam logic [15:0] CHF_IDX_PATH_EXPECTED = 16'h400A;
    localparam logic [15:0] CHF_IDX_PATH_ENABLE = 16'h400C;
    localparam logic [15:0] CHF_IDX_FILTER_STATUS = 16'h4020;
    localparam logic [15:0] CHF_IDX_LAST_ADDRESS = 16'h4022;

    localparam logic [31:0] CHF_ADDR_BIT_COUNT = {14'h0000, CHF_IDX_BIT_COUNT, 2'h0};
    localparam logic [31:0] CHF_ADDR_TABLE_BASE = {14'h0000, CHF_IDX_TABLE_BASE, 2'h0};
    localparam logic [31:0] CHF_ADDR_CH_EXPECTED = {14'h0000, CHF_IDX_CH_EXPECTED, 2'h0};
    localparam logic [31:0] CHF_ADDR_CH_ENABLE = {14'h0000, CHF_IDX_CH_ENABLE, 2'h0};
    localparam logic [31:0] CHF_ADDR_PATH_EXPECTED = {14'h0000, CHF_IDX_PATH_EXPECTED, 2'h0};
    localparam logic [31:0] CHF_ADDR_PATH_ENABLE = {14'h0000, CHF_IDX_PATH_ENABLE, 2'h0};
    localparam logic [31:0] CHF_ADDR_FILTER_STATUS = {14'h0000, CHF_IDX_FILTER_STATUS, 2'h0};
    localparam logic [31:0] CHF_ADDR_LAST_ADDRESS = {14'h0000, CHF_IDX_LAST_ADDRESS, 2'h0};

    // header_bit_count fields
    localparam int CHF_M_LSB = 0;
    localparam int CHF_N_LSB = 4;
    localparam int CHF_PAUSE_BIT = 9;
    // filter_status fields
    localparam int CHF_ST_CFG_ERR_BIT = 0;
    localparam int CHF_ST_ACCEPT_BIT = 1;
    localparam int CHF_ST_CLEAR_BIT = 2;
    localparam int CHF_ST_COUNT_LSB = 16;

    // reset values
    localparam logic [15:0] CHF_RST_REG16 = 16'h0000;
    localparam logic [11:0] CHF_RST_REG12 = 12'h000;

    // header selection limits
    localparam logic [3:0] CHF_M_MAX = 4'hC;
    localparam logic [4:0] CHF_N_MIN = 5'h04;
    localparam logic [4:0] CHF_N_MAX = 5'h10;
    localparam logic [4:0] CHF_INDEX_BITS = 5'h10;

    // look-up address layout
    localparam int CHF_PATH_W = 12;
    localparam int CHF_CH_W = 16;
    localparam int CHF_BASE_LSB = 5;
    localparam int CHF_LUT_AW = 21;
    localparam logic [1:0] CHF_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] CHF_HSIZE_WORD = 3'h2;
endpackage : chf_pkg

// ### logic/chf_bit_match.sv
// per-bit masked compare of a received header field
`timescale 1ns/100ps
`default_nettype none
module chf_bit_match
    import chf_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input wire logic [WIDTH-1:0] rx_bits_in,
    input wire logic [WIDTH-1:0] expected_in,
    input wire logic [WIDTH-1:0] enable_in,
    output logic match_out
);
    logic [WIDTH-1:0] bit_ok;

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
            // disabled bits always pass
            assign bit_ok[gi] = ~enable_in[gi] | (rx_bits_in[gi] == expected_in[gi]);
        end
    endgenerate

    assign match_out = &bit_ok;
endmodule // chf_bit_match
`default_nettype wire

// ### logic/chf_index_form.sv
// forms the external look-up entry byte address from header bits
`timescale 1ns/100ps
`default_nettype none
module chf_index_form
    import chf_pkg::*;
(
    input wire logic [CHF_PATH_W-1:0] path_in,
    input wire logic [CHF_CH_W-1:0] channel_in,
    input wire logic [3:0] path_count_in,
    input wire logic [4:0] channel_count_in,
    input wire logic [15:0] base_in,
    output logic [CHF_LUT_AW-1:0] addr_out
);
    logic [CHF_PATH_W-1:0] path_sel;
    logic [CHF_CH_W-1:0] ch_sel;
    logic [15:0] index;

    genvar gi;
    generate
        for (gi = 0; gi < CHF_PATH_W; gi = gi + 1) begin : g_path
            assign path_sel[gi] = path_in[gi] & (gi < path_count_in);
        end
        for (gi = 0; gi < CHF_CH_W; gi = gi + 1) begin : g_ch
            assign ch_sel[gi] = channel_in[gi] & (gi < channel_count_in);
        end
    endgenerate

    // path bits sit above the channel bits; overflow cannot occur once counts are clamped
    assign index = ({4'h0, path_sel} << channel_count_in) | ch_sel;
    // halfword entries: index fills bits (n+m):1, below the zeroed base bits
    assign addr_out = {base_in, {CHF_BASE_LSB{1'b0}}} | {4'h0, index, 1'b0};
endmodule // chf_index_form
`default_nettype wire

// ### logic/chf_filter_top.sv
// cell header filter and look-up address former with an AHB-Lite register slave
// Notes on behaviour
// RL1: look-up address uses at most 16 header bits
// RL2: software selects at least four header bits
// RL3: base register gives byte address bits 20:5
// RL4: software zeroes base bits (n+m):5 when needed
// RL5: sixteen-bit channel expected register, read/write
// RL6: enabled channel bits must equal expected bits
// RL7: disabled channel bits always count as matching
// RL8: twelve-bit path expected field including flow bits
// RL9: enabled path bits must equal expected bits
// RL10: disabled path bits always count as matching
// RL11: software clears path enables 11:8 for UNI
// RL12: path bit count field, valid 0 to 12
// RL13: channel bit count field, valid 4 to 16
// RL14: base combined with concatenated path/channel bits
// RL15: mismatching cells are not accepted
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module chf_filter_top
    import chf_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic hdr_valid_in,
    input wire logic [CHF_PATH_W-1:0] hdr_path_in,
    input wire logic [CHF_CH_W-1:0] hdr_channel_in,
    output logic cell_valid_out,
    output logic cell_accept_out,
    output logic [CHF_LUT_AW-1:0] lut_addr_out,
    output logic cfg_error_out,
    output logic pause_after_cell_out
);
    // register bank
    logic [3:0] path_count;
    logic [4:0] channel_count;
    logic pause_after_cell;
    logic [15:0] table_base_field;
    logic [15:0] channel_expected_bits;
    logic [15:0] channel_compare_mask;
    logic [11:0] path_expected_bits;
    logic [11:0] path_compare_mask;
    logic [3:0] next_path_count;
    logic [4:0] next_channel_count;
    logic next_pause_after_cell;
    logic [15:0] next_table_base_field;
    logic [15:0] next_channel_expected_bits;
    logic [15:0] next_channel_compare_mask;
    logic [11:0] next_path_expected_bits;
    logic [11:0] next_path_compare_mask;

    // bus state
    logic wr_pend;
    logic [31:0] wr_addr;
    logic [31:0] hrdata;
    logic next_wr_pend;
    logic [31:0] next_wr_addr;
    logic [31:0] next_hrdata;
    logic addr_phase;
    logic [31:0] rd_val;
    logic wr_clear;

    // filter state
    logic cell_valid;
    logic cell_accept;
    logic [CHF_LUT_AW-1:0] lut_addr;
    logic cfg_error;
    logic [15:0] reject_count;
    logic next_cell_valid;
    logic next_cell_accept;
    logic [CHF_LUT_AW-1:0] next_lut_addr;
    logic next_cfg_error;
    logic [15:0] next_reject_count;

    // derived configuration
    logic [3:0] path_lim;
    logic [3:0] eff_path_count;
    logic [4:0] eff_channel_count;
    logic [5:0] sel_sum;
    logic [4:0] path_room;
    logic cfg_bad;
    logic path_ok;
    logic channel_ok;
    logic [CHF_LUT_AW-1:0] formed_addr;

    // RL12 path count clamped to 12
    // RL13 channel count clamped to 4..16
    // RL1 total never beyond 16 bits
    always_comb begin
        path_lim = (path_count > CHF_M_MAX) ? CHF_M_MAX : path_count;
        if (channel_count < CHF_N_MIN) begin
            eff_channel_count = CHF_N_MIN;
        end else if (channel_count > CHF_N_MAX) begin
            eff_channel_count = CHF_N_MAX;
        end else begin
            eff_channel_count = channel_count;
        end
        sel_sum = {2'h0, path_lim} + {1'h0, eff_channel_count};
        path_room = CHF_INDEX_BITS - eff_channel_count;
        // channel bits take priority; path bits shrink to what is left
        if (sel_sum > {1'h0, CHF_INDEX_BITS}) begin
            eff_path_count = path_room[3:0];
        end else begin
            eff_path_count = path_lim;
        end
        // RL2 flag selections software should not use
        cfg_bad = (path_count > CHF_M_MAX) || (channel_count < CHF_N_MIN)
            || (channel_count > CHF_N_MAX)
            || ({2'h0, path_count} + {1'h0, channel_count} > {1'h0, CHF_INDEX_BITS});
    end

    // RL6 channel compare
    // RL7 masked bits pass
    chf_bit_match #(
        .WIDTH(CHF_CH_W)
    ) u_channel_match (
        .rx_bits_in(hdr_channel_in),
        .expected_in(channel_expected_bits),
        .enable_in(channel_compare_mask),
        .match_out(channel_ok)
    );

    // RL9 path compare, flow bits included
    // RL10 masked bits pass
    chf_bit_match #(
        .WIDTH(CHF_PATH_W)
    ) u_path_match (
        .rx_bits_in(hdr_path_in),
        .expected_in(path_expected_bits),
        .enable_in(path_compare_mask),
        .match_out(path_ok)
    );

    // RL14 base plus header index
    chf_index_form u_index (
        .path_in(hdr_path_in),
        .channel_in(hdr_channel_in),
        .path_count_in(eff_path_count),
        .channel_count_in(eff_channel_count),
        .base_in(table_base_field),
        .addr_out(formed_addr)
    );

    // bus: zero wait state, write data applied one cycle after its address phase
    always_comb begin
        addr_phase = hsel_in && hready_in && (htrans_in == CHF_HTRANS_NONSEQ);
        next_wr_pend = addr_phase && hwrite_in && (hsize_in == CHF_HSIZE_WORD);
        next_wr_addr = addr_phase ? haddr_in : wr_addr;
    end

    // register writes
    always_comb begin
        next_path_count = path_count;
        next_channel_count = channel_count;
        next_pause_after_cell = pause_after_cell;
        next_table_base_field = table_base_field;
        next_channel_expected_bits = channel_expected_bits;
        next_channel_compare_mask = channel_compare_mask;
        next_path_expected_bits = path_expected_bits;
        next_path_compare_mask = path_compare_mask;
        wr_clear = 1'b0;
        if (wr_pend) begin
            case (wr_addr)
                CHF_ADDR_BIT_COUNT: begin
                    // RL12 four-bit path count field
                    next_path_count = hwdata_in[CHF_M_LSB +: 4];
                    // RL13 five-bit channel count field
                    next_channel_count = hwdata_in[CHF_N_LSB +: 5];
                    next_pause_after_cell = hwdata_in[CHF_PAUSE_BIT];
                end
                // RL3 sixteen base bits
                CHF_ADDR_TABLE_BASE: next_table_base_field = hwdata_in[15:0];
                // RL5 channel expected value
                CHF_ADDR_CH_EXPECTED: next_channel_expected_bits = hwdata_in[15:0];
                CHF_ADDR_CH_ENABLE: next_channel_compare_mask = hwdata_in[15:0];
                // RL8 twelve path bits
                CHF_ADDR_PATH_EXPECTED: next_path_expected_bits = hwdata_in[11:0];
                CHF_ADDR_PATH_ENABLE: next_path_compare_mask = hwdata_in[11:0];
                CHF_ADDR_FILTER_STATUS: wr_clear = hwdata_in[CHF_ST_CLEAR_BIT];
                default: wr_clear = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            path_count <= CHF_RST_REG16[3:0];
            channel_count <= CHF_RST_REG16[4:0];
            pause_after_cell <= 1'b0;
            table_base_field <= CHF_RST_REG16;
            channel_expected_bits <= CHF_RST_REG16;
            channel_compare_mask <= CHF_RST_REG16;
            path_expected_bits <= CHF_RST_REG12;
            path_compare_mask <= CHF_RST_REG12;
        end else begin
            path_count <= next_path_count;
            channel_count <= next_channel_count;
            pause_after_cell <= next_pause_after_cell;
            table_base_field <= next_table_base_field;
            channel_expected_bits <= next_channel_expected_bits;
            channel_compare_mask <= next_channel_compare_mask;
            path_expected_bits <= next_path_expected_bits;
            path_compare_mask <= next_path_compare_mask;
        end
    end

    // read mux looks at next values so a read right after a write sees it
    always_comb begin
        rd_val = 32'h00000000;
        case (haddr_in)
            CHF_ADDR_BIT_COUNT: begin
                rd_val[CHF_M_LSB +: 4] = next_path_count;
                rd_val[CHF_N_LSB +: 5] = next_channel_count;
                rd_val[CHF_PAUSE_BIT] = next_pause_after_cell;
            end
            CHF_ADDR_TABLE_BASE: rd_val[15:0] = next_table_base_field;
            CHF_ADDR_CH_EXPECTED: rd_val[15:0] = next_channel_expected_bits;
            CHF_ADDR_CH_ENABLE: rd_val[15:0] = next_channel_compare_mask;
            CHF_ADDR_PATH_EXPECTED: rd_val[11:0] = next_path_expected_bits;
            CHF_ADDR_PATH_ENABLE: rd_val[11:0] = next_path_compare_mask;
            CHF_ADDR_FILTER_STATUS: begin
                rd_val[CHF_ST_CFG_ERR_BIT] = next_cfg_error;
                rd_val[CHF_ST_ACCEPT_BIT] = next_cell_accept;
                rd_val[CHF_ST_COUNT_LSB +: 16] = next_reject_count;
            end
            CHF_ADDR_LAST_ADDRESS: rd_val[CHF_LUT_AW-1:0] = next_lut_addr;
            default: rd_val = 32'h00000000;
        endcase
        next_hrdata = (addr_phase && !hwrite_in) ? rd_val : hrdata;
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wr_pend <= 1'b0;
            wr_addr <= 32'h00000000;
            hrdata <= 32'h00000000;
        end else begin
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            hrdata <= next_hrdata;
        end
    end

    // cell filtering, one cycle from header to verdict
    always_comb begin
        next_cell_valid = hdr_valid_in;
        next_cell_accept = cell_accept;
        next_lut_addr = lut_addr;
        next_cfg_error = cfg_bad;
        next_reject_count = wr_clear ? 16'h0000 : reject_count;
        if (hdr_valid_in) begin
            // RL15 reject on any enabled mismatch
            next_cell_accept = path_ok && channel_ok;
            // RL14 entry address for this cell
            next_lut_addr = formed_addr;
            // a reject in the clearing cycle is still counted
            if (!(path_ok && channel_ok)) begin
                next_reject_count = (wr_clear ? 16'h0000 : reject_count) + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cell_valid <= 1'b0;
            cell_accept <= 1'b0;
            lut_addr <= {CHF_LUT_AW{1'b0}};
            cfg_error <= 1'b0;
            reject_count <= 16'h0000;
        end else begin
            cell_valid <= next_cell_valid;
            cell_accept <= next_cell_accept;
            lut_addr <= next_lut_addr;
            cfg_error <= next_cfg_error;
            reject_count <= next_reject_count;
        end
    end

    // hready and response are constant flops: the slave never stalls or errors
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
        end else begin
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
        end
    end

    assign hrdata_out = hrdata;
    assign cell_valid_out = cell_valid;
    assign cell_accept_out = cell_accept;
    assign lut_addr_out = lut_addr;
    assign cfg_error_out = cfg_error;
    assign pause_after_cell_out = pause_after_cell;
endmodule // chf_filter_top
`default_nettype wire

// ### sim/chf_cell_src.sv
// far-end model that presents received cell headers
`timescale 1ns/100ps
`default_nettype none
module chf_cell_src
    import chf_pkg::*;
(
    input wire logic clk_in,
    output logic hdr_valid_out,
    output logic [CHF_PATH_W-1:0] hdr_path_out,
    output logic [CHF_CH_W-1:0] hdr_channel_out
);
    initial begin
        hdr_valid_out = 1'h0;
        hdr_path_out = 12'h000;
        hdr_channel_out = 16'h0000;
    end

    // gap cycles model a slow far end
    task automatic send(input logic [11:0] p, input logic [15:0] c, input int gap);
        repeat (gap) @(posedge clk_in);
        hdr_valid_out <= 1'h1;
        hdr_path_out <= p;
        hdr_channel_out <= c;
        @(posedge clk_in);
        hdr_valid_out <= 1'h0;
        // unqualified fields show garbage so stale values cannot pass
        hdr_path_out <= ~p;
        hdr_channel_out <= ~c;
    endtask
endmodule // chf_cell_src
`default_nettype wire

// ### sim/chf_filter_monitor.sv
// concurrent checks on the filter top ports
`timescale 1ns/100ps
`default_nettype none
module chf_filter_monitor
    import chf_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic hdr_valid_in,
    input wire logic [CHF_PATH_W-1:0] hdr_path_in,
    input wire logic [CHF_CH_W-1:0] hdr_channel_in,
    input wire logic cell_valid_out,
    input wire logic cell_accept_out,
    input wire logic [CHF_LUT_AW-1:0] lut_addr_out,
    input wire logic cfg_error_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    localparam logic [15:0] MSK [6] = '{16'h03FF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0FFF, 16'h0FFF};
    // register copies snooped from the bus
    logic [15:0] sh [6];
    logic [15:0] next_sh [6];
    logic [15:0] ix_q, next_ix;
    logic wr_q, next_wr, up_q, take, ok, bad, ch_bad, p_bad;
    logic [2:0] k;
    logic [3:0] m;
    logic [4:0] n;
    logic [31:0] idx;
    logic [20:0] exp_addr;
    assign take = hsel_in && hready_in && htrans_in == CHF_HTRANS_NONSEQ;
    assign ok = ix_q >= CHF_IDX_BIT_COUNT && ix_q <= CHF_IDX_PATH_ENABLE && !ix_q[0];
    assign k = 3'((ix_q - CHF_IDX_BIT_COUNT) >> 1);
    always_comb begin
        next_sh = sh;
        next_wr = take && hwrite_in && hsize_in == CHF_HSIZE_WORD;
        next_ix = take ? haddr_in[17:2] : ix_q;
        if (wr_q && ok) begin
            next_sh[k] = hwdata_in[15:0] & MSK[k];
        end
    end
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sh <= '{default: 16'h0000};
            ix_q <= 16'h0000;
            wr_q <= 1'h0;
            up_q <= 1'h0;
        end else begin
            sh <= next_sh;
            ix_q <= next_ix;
            wr_q <= next_wr;
            up_q <= 1'h1;
        end
    end
    // invalid counts are clamped, so the index never exceeds sixteen bits
    always_comb begin
        m = sh[0][3:0];
        n = sh[0][8:4];
        bad = m > CHF_M_MAX || n < CHF_N_MIN || n > CHF_N_MAX
            || 6'(m) + 6'(n) > 6'(CHF_INDEX_BITS);
        if (n < CHF_N_MIN) n = CHF_N_MIN;
        if (n > CHF_N_MAX) n = CHF_N_MAX;
        if (m > CHF_M_MAX) m = CHF_M_MAX;
        if (5'(m) + n > CHF_INDEX_BITS) m = 4'(CHF_INDEX_BITS - n);
        idx = ((32'(hdr_path_in) & ((32'h1 << m) - 32'h1)) << n)
            | (32'(hdr_channel_in) & ((32'h1 << n) - 32'h1));
        exp_addr = 21'({sh[1], 5'h00} | (idx << 1));
        ch_bad = |(sh[3] & (hdr_channel_in ^ sh[2]));
        p_bad = |(sh[5][11:0] & (hdr_path_in ^ sh[4][11:0]));
    end
    sequence s_rd;
        take && !hwrite_in;
    endsequence
    sequence s_cell;
        hdr_valid_in;
    endsequence
    cell_reply_a: assert property (s_cell |=> cell_valid_out)
        else $error("no cell reply");
    no_spurious_a: assert property (!hdr_valid_in |=> !cell_valid_out)
        else $error("reply without header");
    channel_reject_a: assert property (s_cell and ch_bad |=> !cell_accept_out)
        else $error("channel mismatch accepted");
    path_reject_a: assert property (s_cell and p_bad |=> !cell_accept_out)
        else $error("path mismatch accepted");
    masked_pass_a: assert property (s_cell and !ch_bad && !p_bad |=> cell_accept_out)
        else $error("matching cell refused");
    lut_index_a: assert property (s_cell |=> lut_addr_out == $past(exp_addr))
        else $error("wrong table address");
    base_bits_a: assert property (s_cell |=> (lut_addr_out[20:5] & $past(sh[1])) == $past(sh[1]))
        else $error("base bits lost");
    verdict_hold_a: assert property (!hdr_valid_in |=> $stable(lut_addr_out) && $stable(cell_accept_out))
        else $error("verdict moved without cell");
    count_check_a: assert property (up_q |-> cfg_error_out == $past(bad))
        else $error("bit count error flag wrong");
    reg_readback_a: assert property (s_rd ##1 ok |-> hrdata_out == {16'h0000, sh[k]})
        else $error("register read wrong");
endmodule // chf_filter_monitor

bind chf_filter_top chf_filter_monitor u_chf_filter_monitor (.clk_in(clk_in), .rstn_in(rstn_in),
    .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
    .hsize_in(hsize_in), .hwdata_in(hwdata_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
    .hdr_valid_in(hdr_valid_in), .hdr_path_in(hdr_path_in), .hdr_channel_in(hdr_channel_in),
    .cell_valid_out(cell_valid_out), .cell_accept_out(cell_accept_out),
    .lut_addr_out(lut_addr_out), .cfg_error_out(cfg_error_out));
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench: registers over AHB-Lite, then header filtering
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import chf_pkg::*;
    localparam int LIMIT = 5000;
    logic clk_in = 1'h0;
    logic rstn_in = 1'h0;
    logic hsel_in = 1'h0;
    logic hwrite_in = 1'h0;
    logic [1:0] htrans_in = 2'h0;
    logic [2:0] hsize_in = 3'h0;
    logic [31:0] haddr_in = 32'h0;
    logic [31:0] hwdata_in = 32'h0;
    logic [31:0] hrdata_out, rd;
    logic hreadyout_out, hresp_out, hdr_valid_in, cell_valid_out, cell_accept_out;
    logic cfg_error_out, pause_after_cell_out;
    logic [11:0] hdr_path_in;
    logic [15:0] hdr_channel_in, base;
    logic [20:0] lut_addr_out;
    logic [15:0] channel_expected_bits = 16'hC35A, channel_compare_mask = 16'h0F0F;
    logic [11:0] path_expected_bits = 12'h9A6, path_compare_mask = 12'h0FF;
    logic [31:0] addrs [6] = '{CHF_ADDR_BIT_COUNT, CHF_ADDR_TABLE_BASE, CHF_ADDR_CH_EXPECTED,
        CHF_ADDR_CH_ENABLE, CHF_ADDR_PATH_EXPECTED, CHF_ADDR_PATH_ENABLE};
    logic [31:0] masks [6] = '{32'h3FF, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFF, 32'hFFF};
    // none, enabled and disabled bit flips of {path, channel}
    logic [27:0] flips [6] = '{28'h0000000, 28'h0000100, 28'h0001000, 28'h0010000,
        28'h8000000, 28'hF00F0F0};
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    int m, n;

    always #10 clk_in = ~clk_in;

    chf_filter_top u_chf_filter_top (.clk_in(clk_in), .rstn_in(rstn_in), .hsel_in(hsel_in),
        .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
        .hsize_in(hsize_in), .hwdata_in(hwdata_in), .hready_in(hreadyout_out),
        .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
        .hdr_valid_in(hdr_valid_in), .hdr_path_in(hdr_path_in),
        .hdr_channel_in(hdr_channel_in), .cell_valid_out(cell_valid_out),
        .cell_accept_out(cell_accept_out), .lut_addr_out(lut_addr_out),
        .cfg_error_out(cfg_error_out), .pause_after_cell_out(pause_after_cell_out));
    chf_cell_src u_chf_cell_src (.clk_in(clk_in), .hdr_valid_out(hdr_valid_in),
        .hdr_path_out(hdr_path_in), .hdr_channel_out(hdr_channel_in));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_errors++;
            stop_test();
        end
    end

    // one single word transfer; each phase waits for hreadyout_out, so wait states are allowed
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel_in <= 1'h1;
        haddr_in <= a;
        hwrite_in <= wr;
        htrans_in <= CHF_HTRANS_NONSEQ;
        hsize_in <= CHF_HSIZE_WORD;
        @(posedge clk_in);
        while (hreadyout_out !== 1'h1) @(posedge clk_in);
        htrans_in <= 2'h0;
        hwdata_in <= d;
        @(posedge clk_in);
        while (hreadyout_out !== 1'h1) @(posedge clk_in);
        rd = hrdata_out;
        check(32'(hresp_out), 32'h0);
    endtask

    function automatic logic acc(input logic [27:0] h);
        return !(|(channel_compare_mask & (h[15:0] ^ channel_expected_bits)))
            && !(|(path_compare_mask & (h[27:16] ^ path_expected_bits)));
    endfunction

    function automatic logic [20:0] lut(input logic [27:0] h);
        logic [31:0] i;
        i = ((32'(h[27:16]) & ((32'h1 << m) - 32'h1)) << n)
            | (32'(h[15:0]) & ((32'h1 << n) - 32'h1));
        return 21'({base, 5'h00} | (i << 1));
    endfunction

    task automatic cfg(input int mm, input int nn);
        logic [27:0] h;
        logic e;
        n = (nn < 4) ? 4 : (nn > 16) ? 16 : nn;
        m = (mm > 12) ? 12 : mm;
        if (m + n > 16)
            m = 16 - n;
        base = 16'hA5A5 & ~((16'h1 << (m + n - 4)) - 16'h1);
        bus(1'h1, CHF_ADDR_BIT_COUNT, 32'h200 | 32'(nn * 16 + mm));
        bus(1'h1, CHF_ADDR_TABLE_BASE, 32'(base));
        bus(1'h1, CHF_ADDR_CH_EXPECTED, 32'(channel_expected_bits));
        bus(1'h1, CHF_ADDR_CH_ENABLE, 32'(channel_compare_mask));
        bus(1'h1, CHF_ADDR_PATH_EXPECTED, 32'(path_expected_bits));
        bus(1'h1, CHF_ADDR_PATH_ENABLE, 32'(path_compare_mask));
        e = mm > 12 || nn < 4 || nn > 16 || mm + nn > 16;
        check(32'(cfg_error_out), 32'(e));
        check(32'(pause_after_cell_out), 32'h1);
        // restart the reject count for this setting
        bus(1'h1, CHF_ADDR_FILTER_STATUS, 32'h4);
        foreach (flips[j]) begin
            h = {path_expected_bits, channel_expected_bits} ^ flips[j];
            // gap of at least one keeps header changes on a clock edge
            u_chf_cell_src.send(h[27:16], h[15:0], j % 3 + 1);
            #1;
            check(32'(cell_valid_out), 32'h1);
            check(32'(cell_accept_out), 32'(acc(h)));
            check(32'(lut_addr_out), 32'(lut(h)));
            @(posedge clk_in);
            #1;
            check(32'(cell_valid_out), 32'h0);
            check(32'(lut_addr_out), 32'(lut(h)));
        end
        @(posedge clk_in);
        bus(1'h0, CHF_ADDR_LAST_ADDRESS, 32'h0);
        check(rd, 32'(lut(h)));
        // two of the six headers differ in enabled bits
        bus(1'h0, CHF_ADDR_FILTER_STATUS, 32'h0);
        check(rd, {16'h0002, 14'h0000, acc(h), e});
    endtask

    initial begin
        repeat (10) @(posedge clk_in);
        rstn_in <= 1'h1;
        @(posedge clk_in);
        for (int i = 0; i < 6; i++) begin
            bus(1'h0, addrs[i], 32'h0);
            check(rd, 32'h0);
            bus(1'h1, addrs[i], 32'hFFFFFFFF);
            bus(1'h0, addrs[i], 32'h0);
            check(rd, masks[i]);
            bus(1'h1, addrs[i], 32'h0);
        end
        // unmapped place: write dropped, read gives zero
        bus(1'h1, 32'h00010000, 32'hFFFFFFFF);
        bus(1'h0, 32'h00010000, 32'h0);
        check(rd, 32'h0);
        cfg(0, 16);
        cfg(12, 4);
        cfg(5, 7);
        cfg(13, 3);
        cfg(12, 16);
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
